// ===== hdl/secure_boot_area_select.sv
// secure boot-area selector with apb status port
`timescale 1ns/1ps

// Summary of operation
// - trust off, open state, pin low boots from the nonsecure vector.
// - trust on, open state, pin low boots from the secure vector.
// - trust off, open state, pin high boots the system bootloader.
// - provisioning state always boots the root secure services area.
// - with selector, trust on, open, pin high: 0xb4 bootloader, 0xc3 rot.
// - the selector is bits 29 to 22 of the option status word.
// - with selector, trust on, later states: 0xc3 rot, 0xb4 secure vector.
// - trust off in later states always boots from the nonsecure vector.
// - without selector, trust on: open pin high bootloader, else secure.
// - boot vectors supply only bits 31 to 8, so low byte is zero.
// - factory vectors are 0x08000000 nonsecure and 0x0c000000 secure.
// - a debug request at boot launches debug authentication.
// - each boot loads the initial hide-protection level before running.
module secure_boot_area_select #(
  parameter bit has_selector = 1'b1
) (
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  input  wire logic                   ce_in,
  input  wire logic                   boot_select_pin_in,
  input  wire logic                   dbg_req_in,
  input  wire boot_sel_pkg::options_t opt_in,
  input  wire logic [7:0]             hide_init_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [7:0]             paddr_in,
  input  wire logic [31:0]            pwdata_in,
  output logic [31:0]                 prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  output boot_sel_pkg::boot_choice_t  choice_out,
  output logic                        boot_done_out,
  output logic                        dbg_auth_start_out,
  output logic [7:0]                  hide_level_out
);

  // ---------------------------------------------------------------------------
  // sampled settings
  // ---------------------------------------------------------------------------
  boot_sel_pkg::phase_t       phase_reg;
  boot_sel_pkg::phase_t       phase_next;
  boot_sel_pkg::options_t     opt_reg;
  logic                       pin_reg;
  logic                       dbg_reg;
  boot_sel_pkg::boot_choice_t choice_reg;
  logic [7:0]                 hide_reg;
  logic                       dbg_start_reg;
  logic                       dbg_ack_reg;
  logic [31:0]                rdata_reg;

  // defaults model factory state until the first sample after reset
  boot_sel_pkg::options_t opt_default;
  assign opt_default = '{
    trust_partition_enable: boot_sel_pkg::code_disabled,
    option_status_word:     {2'b00, boot_sel_pkg::sel_reset, 22'h000000},
    nonsecure_boot_vector:  boot_sel_pkg::ns_vec_reset,
    secure_boot_vector:     boot_sel_pkg::s_vec_reset,
    life_state:             boot_sel_pkg::st_open
  };

  // ---------------------------------------------------------------------------
  // boot decision
  // ---------------------------------------------------------------------------
  function automatic boot_sel_pkg::boot_choice_t decide(
    input boot_sel_pkg::options_t o,
    input logic                   pin,
    input bit                     sel_variant
  );
    logic [7:0]                 sel;
    logic                       trust_off;
    logic                       sel_secure;
    logic [31:0]                ns_addr;
    logic [31:0]                s_addr;
    boot_sel_pkg::boot_choice_t c;
    sel        = o.option_status_word[boot_sel_pkg::sel_msb:
                                      boot_sel_pkg::sel_lsb];
    // anything but the disable code counts as trust on
    trust_off  = (o.trust_partition_enable == boot_sel_pkg::code_disabled);
    sel_secure = (sel == boot_sel_pkg::code_enabled);
    ns_addr    = {o.nonsecure_boot_vector, 8'h00};
    s_addr     = {o.secure_boot_vector, 8'h00};
    c.trust_on = !trust_off;
    c.address  = ns_addr;
    c.area     = boot_sel_pkg::area_user_flash;
    if (o.life_state == boot_sel_pkg::st_provisioning) begin
      c.area    = boot_sel_pkg::area_root_secure;
      c.address = 32'h00000000;
    end else if (trust_off) begin
      if (o.life_state == boot_sel_pkg::st_open && pin) begin
        c.area    = boot_sel_pkg::area_bootloader;
        c.address = 32'h00000000;
      end else begin
        c.address = ns_addr;
      end
    end else if (o.life_state == boot_sel_pkg::st_open) begin
      if (!pin) begin
        c.address = s_addr;
      end else if (!sel_variant || sel_secure) begin
        c.area    = boot_sel_pkg::area_bootloader;
        c.address = 32'h00000000;
      end else begin
        c.area    = boot_sel_pkg::area_customer_rot;
        c.address = 32'h00000000;
      end
    end else if (!sel_variant || sel_secure) begin
      c.address = s_addr;
    end else begin
      c.area    = boot_sel_pkg::area_customer_rot;
      c.address = 32'h00000000;
    end
    return c;
  endfunction : decide

  // ---------------------------------------------------------------------------
  // boot sequencing
  // ---------------------------------------------------------------------------
  always_comb begin
    case (phase_reg)
      boot_sel_pkg::ph_reset: phase_next = boot_sel_pkg::ph_load;
      boot_sel_pkg::ph_load:  phase_next = boot_sel_pkg::ph_run;
      boot_sel_pkg::ph_run:   phase_next = boot_sel_pkg::ph_run;
      default:                phase_next = boot_sel_pkg::ph_reset;
    endcase
  end

  wire sample_now = (phase_reg == boot_sel_pkg::ph_reset);
  wire load_now   = (phase_reg == boot_sel_pkg::ph_load);

  // sampling only in the first cycle after release keeps the choice stable
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      phase_reg <= boot_sel_pkg::ph_reset;
      opt_reg   <= opt_default;
      pin_reg   <= 1'b0;
      dbg_reg   <= 1'b0;
    end else if (ce_in) begin
      phase_reg <= phase_next;
      if (sample_now) begin
        opt_reg <= opt_in;
        pin_reg <= boot_select_pin_in;
        dbg_reg <= dbg_req_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      choice_reg <= '0;
      hide_reg   <= boot_sel_pkg::hide_reset;
    end else if (ce_in && load_now) begin
      choice_reg <= decide(opt_reg, pin_reg, has_selector);
      hide_reg   <= hide_init_in;
    end
  end

  // ---------------------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------------------
  wire apb_access = psel_in && penable_in;
  wire apb_wr     = apb_access && pwrite_in;
  wire apb_rd     = apb_access && !pwrite_in;
  wire ack_write  = apb_wr && (paddr_in == boot_sel_pkg::off_ack);
  wire hit_status = (paddr_in == boot_sel_pkg::off_status);
  wire hit_addr   = (paddr_in == boot_sel_pkg::off_address);
  wire hit_hide   = (paddr_in == boot_sel_pkg::off_hide);
  wire hit_ns     = (paddr_in == boot_sel_pkg::off_ns_vec);
  wire hit_s      = (paddr_in == boot_sel_pkg::off_s_vec);
  wire hit_any    = hit_status || hit_addr || hit_hide || hit_ns ||
                    hit_s || (paddr_in == boot_sel_pkg::off_ack);
  wire running    = (phase_reg == boot_sel_pkg::ph_run);

  // debug start: pulse-free level until software acknowledges it
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      dbg_start_reg <= 1'b0;
      dbg_ack_reg   <= 1'b0;
    end else if (ce_in) begin
      if (load_now && dbg_reg) begin
        dbg_start_reg <= 1'b1;
      end else if (ack_write && pwdata_in[0]) begin
        dbg_start_reg <= 1'b0;
        dbg_ack_reg   <= 1'b1;
      end
    end
  end

  logic [31:0] rd_mux;
  assign rd_mux =
    hit_status ? {24'h000000, dbg_ack_reg, dbg_start_reg, running,
                  choice_reg.trust_on, 2'b00, choice_reg.area} :
    hit_addr   ? choice_reg.address :
    hit_hide   ? {24'h000000, hide_reg} :
    hit_ns     ? {opt_reg.nonsecure_boot_vector, 8'h00} :
    hit_s      ? {opt_reg.secure_boot_vector, 8'h00} :
    32'h00000000;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_reg <= 32'h00000000;
    end else if (ce_in && psel_in && !penable_in && !pwrite_in) begin
      rdata_reg <= rd_mux;
    end
  end

  assign pready_out         = 1'b1;
  assign pslverr_out        = apb_access && !hit_any;
  assign prdata_out         = apb_rd ? rdata_reg : 32'h00000000;
  assign choice_out         = running ? choice_reg : '0;
  assign boot_done_out      = running;
  assign dbg_auth_start_out = dbg_start_reg;
  assign hide_level_out     = hide_reg;

endmodule : secure_boot_area_select

// ===== inc/boot_sel_pkg.sv
// package: constants, enums and carrier structs for the boot-area selector
package boot_sel_pkg;

  // ---------------------------------------------------------------------------
  // option codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] code_disabled = 8'hc3;
  localparam logic [7:0] code_enabled  = 8'hb4;
  localparam int         sel_msb       = 29;
  localparam int         sel_lsb       = 22;
  localparam int         vec_lsb       = 8;
  localparam logic [23:0] ns_vec_reset = 24'h080000;
  localparam logic [23:0] s_vec_reset  = 24'h0c0000;
  localparam logic [7:0]  sel_reset    = 8'hc3;

  // ---------------------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] off_status   = 8'h00;
  localparam logic [7:0] off_address  = 8'h04;
  localparam logic [7:0] off_hide     = 8'h08;
  localparam logic [7:0] off_ns_vec   = 8'h0c;
  localparam logic [7:0] off_s_vec    = 8'h10;
  localparam logic [7:0] off_ack      = 8'h14;
  localparam int         hide_w       = 8;
  localparam logic [7:0] hide_reset   = 8'h01;

  typedef enum logic [2:0] {
    st_open         = 3'b000,
    st_provisioning = 3'b001,
    st_provisioned  = 3'b010,
    st_trust_closed = 3'b011,
    st_closed       = 3'b100,
    st_locked       = 3'b101
  } life_state_t;

  typedef enum logic [1:0] {
    area_user_flash  = 2'b00,
    area_bootloader  = 2'b01,
    area_root_secure = 2'b10,
    area_customer_rot = 2'b11
  } boot_area_t;

  typedef enum logic [1:0] {
    ph_reset = 2'b00,
    ph_load  = 2'b01,
    ph_run   = 2'b10
  } phase_t;

  typedef struct packed {
    logic [7:0]  trust_partition_enable;
    logic [31:0] option_status_word;
    logic [23:0] nonsecure_boot_vector;
    logic [23:0] secure_boot_vector;
    life_state_t life_state;
  } options_t;

  typedef struct packed {
    boot_area_t  area;
    logic [31:0] address;
    logic        trust_on;
  } boot_choice_t;

endpackage : boot_sel_pkg

// ===== testbench/boot_option_store.sv
// model of the option storage and boot pin
`timescale 1ns/1ps
module boot_option_store (
  input  wire logic [20:0]       cfg_in,
  output boot_sel_pkg::options_t opt_out,
  output logic                   pin_out,
  output logic                   dbg_out,
  output logic [7:0]             hide_out
);
  // ------
  // cfg_in: trust, state, pin, selector, factory
  // ------
  wire fac = cfg_in[0];
  assign opt_out.trust_partition_enable = cfg_in[20:13];
  // other bits high so a shifted selector slice shows up
  assign opt_out.option_status_word = {2'b11, cfg_in[8:1], 22'h3fffff};
  assign opt_out.nonsecure_boot_vector =
    fac ? boot_sel_pkg::ns_vec_reset : 24'h08abcd;
  assign opt_out.secure_boot_vector =
    fac ? boot_sel_pkg::s_vec_reset : 24'h0c1234;
  assign opt_out.life_state = boot_sel_pkg::life_state_t'(cfg_in[12:10]);
  assign pin_out = cfg_in[9];
  assign dbg_out = fac;
  assign hide_out = cfg_in[20:13] ^ cfg_in[8:1];
endmodule : boot_option_store

// ===== testbench/boot_sel_properties.sv
// checker: boot-area choice properties
`timescale 1ns/1ps
module boot_sel_properties (
  input wire logic                       clk_in,
  input wire logic                       nrst_in,
  input wire logic                       boot_select_pin_in,
  input wire boot_sel_pkg::options_t     opt_in,
  input wire logic [7:0]                 hide_init_in,
  input wire boot_sel_pkg::boot_choice_t choice_out,
  input wire logic                       boot_done_out,
  input wire logic [7:0]                 hide_level_out
);
  // ------
  // decoded settings
  // ------
  wire        off  = opt_in.trust_partition_enable == 8'hc3;
  wire        op   = opt_in.life_state == boot_sel_pkg::st_open;
  wire        prov = opt_in.life_state == boot_sel_pkg::st_provisioning;
  wire        pin  = boot_select_pin_in;
  wire        rot  = opt_in.option_status_word[29:22] != 8'hb4;
  wire [31:0] ns   = {opt_in.nonsecure_boot_vector, 8'h00};
  wire [31:0] sc   = {opt_in.secure_boot_vector, 8'h00};
  wire [1:0]  ar   = choice_out.area;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_boot(c);
    $rose(boot_done_out) && c;
  endsequence
  a_open_nonsecure: assert property (s_boot(off && op && !pin)
    |-> choice_out.address == ns) else $error("bad nonsecure boot");
  a_open_secure: assert property (s_boot(!off && op && !pin)
    |-> choice_out.address == sc) else $error("bad secure boot");
  a_open_loader: assert property (s_boot(off && op && pin)
    |-> ar == boot_sel_pkg::area_bootloader) else $error("bad loader");
  a_provision_rss: assert property (s_boot(prov)
    |-> ar == boot_sel_pkg::area_root_secure) else $error("bad rss");
  a_customer_rot: assert property (s_boot(!off && !prov && (pin || !op) &&
    rot) |-> ar == boot_sel_pkg::area_customer_rot)
    else $error("bad rot");
  a_later_nonsecure: assert property (s_boot(off && !op && !prov)
    |-> choice_out.address == ns) else $error("bad late boot");
  a_hide_load: assert property (s_boot(1'b1)
    |-> hide_level_out == hide_init_in) else $error("bad hide level");
  a_choice_held: assert property (boot_done_out && $past(boot_done_out)
    |-> $stable(choice_out)) else $error("choice moved");
endmodule : boot_sel_properties

bind secure_boot_area_select boot_sel_properties boot_sel_properties_inst (
  .clk_in(clk_in), .nrst_in(nrst_in),
  .boot_select_pin_in(boot_select_pin_in), .opt_in(opt_in),
  .hide_init_in(hide_init_in), .choice_out(choice_out),
  .boot_done_out(boot_done_out), .hide_level_out(hide_level_out));

// ===== testbench/tb_secure_boot_area_select.sv
// testbench: boot choices and the apb status port
`timescale 1ns/1ps
module tb_secure_boot_area_select;
  logic        clk_in;
  logic        nrst_in    = 1'b0;
  logic        psel_in    = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in  = 1'b0;
  logic [7:0]  paddr_in   = 8'h00;
  logic [31:0] pwdata_in  = 32'h0;
  logic [20:0] cfg        = 21'h0;
  logic [31:0] prdata_out, rd;
  logic [7:0]  hide_init_in, hide_level_out;
  logic        pready_out, pslverr_out, boot_done_out, dbg_auth_start_out;
  logic        pin, dbg, err;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  boot_sel_pkg::options_t     opt;
  boot_sel_pkg::boot_choice_t choice_out;
  wire [31:0]  got = {choice_out.area, choice_out.address[29:0]};
  boot_option_store boot_option_store_inst (.cfg_in(cfg), .opt_out(opt),
    .pin_out(pin), .dbg_out(dbg), .hide_out(hide_init_in));
  secure_boot_area_select secure_boot_area_select_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .boot_select_pin_in(pin), .dbg_req_in(dbg), .opt_in(opt),
    .hide_init_in(hide_init_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .choice_out(choice_out),
    .boot_done_out(boot_done_out), .dbg_auth_start_out(dbg_auth_start_out),
    .hide_level_out(hide_level_out));
  // ------
  // tasks
  // ------
  task automatic end_of_test;
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic cmp(input string what, input logic [31:0] exp, act);
    n_checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic ok;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    penable_in <= 1'b0;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    // request stands until the edge that samples pready high
    do begin
      @(posedge clk_in);
      ok = pready_out;
      rd = prdata_out;
      err = pslverr_out;
      n++;
    end while (ok !== 1'b1 && n < 20);
    if (ok !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic boot_case(input logic [7:0] t, input logic [2:0] s,
      input logic p, input logic [7:0] u, input logic f, input logic [1:0] a,
      input logic [31:0] ad);
    int n;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    cfg <= {t, s, p, u, f};
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    n = 0;
    while (boot_done_out !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    if (boot_done_out !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    cmp("choice", {a, ad[29:0]}, got);
    apb(1'b0, 8'h00, 32'h0);
    cmp("status", {25'h0, f, 1'b1, t != 8'hc3, 2'b00, a}, rd & 32'h73);
    apb(1'b0, 8'h04, 32'h0);
    cmp("address", ad, rd);
    cfg[9] <= ~p;
    repeat (3) @(negedge clk_in);
    cmp("held", {a, ad[29:0]}, got);
  endtask : boot_case
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (12) @(posedge clk_in);
    boot_case(8'hc3, 3'h0, 1'b0, 8'hb4, 1'b1, 2'h0, 32'h08000000);
    boot_case(8'hb4, 3'h0, 1'b0, 8'hc3, 1'b1, 2'h0, 32'h0c000000);
    boot_case(8'hc3, 3'h0, 1'b1, 8'hc3, 1'b0, 2'h1, 32'h0);
    boot_case(8'hb4, 3'h1, 1'b1, 8'hb4, 1'b0, 2'h2, 32'h0);
    boot_case(8'hc3, 3'h1, 1'b0, 8'hc3, 1'b1, 2'h2, 32'h0);
    boot_case(8'hb4, 3'h0, 1'b1, 8'hb4, 1'b0, 2'h1, 32'h0);
    boot_case(8'hb4, 3'h0, 1'b1, 8'hc3, 1'b1, 2'h3, 32'h0);
    boot_case(8'hb4, 3'h4, 1'b0, 8'hc3, 1'b0, 2'h3, 32'h0);
    boot_case(8'hb4, 3'h3, 1'b1, 8'hb4, 1'b0, 2'h0, 32'h0c123400);
    boot_case(8'hc3, 3'h5, 1'b1, 8'hb4, 1'b0, 2'h0, 32'h08abcd00);
    boot_case(8'hc3, 3'h2, 1'b0, 8'hc3, 1'b1, 2'h0, 32'h08000000);
    boot_case(8'h5a, 3'h0, 1'b1, 8'h77, 1'b1, 2'h3, 32'h0);
    apb(1'b1, 8'h08, 32'hffffffff);
    apb(1'b0, 8'h08, 32'h0);
    cmp("hide", 32'h2d, rd);
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    cmp("debug", 32'h80, rd & 32'hc0);
    apb(1'b0, 8'h40, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, err});
    end_of_test();
  end
endmodule : tb_secure_boot_area_select
